// *** inc/psrc_pkg.sv ***
// constants and types for the power sense reset control block
// Function
// - External reset drops at once on power-on sense low, held while low.
// - After power-on sense rises, reset stays low until software release.
// - External reset drops about 5us after power-good loss or internal reset.
// - Every automatic external reset assertion lasts at least 2ms before release.
// - A software control drives the external reset independent of sequencing.
// - Power-good loss past the window parks mirrors, then resets controller.
// - Controller, once in reset, held there for as long as power-good stays low.
// - Power-good counts active only after a minimum continuous high time.
package psrc_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_HZ     = 100_000_000;
	localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_FREQ_HZ;
	localparam int EXT_DELAY_NS    = 5_000;
	localparam int EXT_DELAY_CYC   = EXT_DELAY_NS / CLK_PERIOD_NS;
	localparam int STRETCH_MS      = 2;
	localparam int STRETCH_CYC     = (STRETCH_MS * 1_000_000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PG_LOW_NS       = 1_000;
	localparam int PG_LOW_CYC      = (PG_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PG_HIGH_NS      = 10_000;
	localparam int PG_HIGH_CYC     = (PG_HIGH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W           = 24;
	localparam int SYNC_STAGES     = 3;
	// ---------------------------------------------------------------
	// controller sequencing states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		PSRC_RUN   = 4'b0001,
		PSRC_PARK  = 4'b0010,
		PSRC_HOLD  = 4'b0100,
		PSRC_QUAL  = 4'b1000
	} psrc_state_t;
endpackage

// *** rtl/psrc_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module psrc_sync (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic async_in,
	output var  logic level_q
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_d;

	// next values: a change counts once second and third stages agree
	always_comb begin
		stage_d = {stage_q[1:0], async_in};
		level_d = level_q;
		if (stage_q[1] == stage_q[2]) begin
			level_d = stage_q[2];
		end
	end

	// registers; inputs park low so reset looks like power absent
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end
endmodule
`default_nettype wire

// *** rtl/psrc_top.sv ***
// power sense reset control: input qualification and reset sequencing
`timescale 1ns/100ps
`default_nettype none
module psrc_top
	import psrc_pkg::*;
#(
	parameter int STRETCH_CYCLES = STRETCH_CYC
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic power_on_sense,
	input  wire logic power_good_in,
	input  wire logic sw_release,
	input  wire logic sw_force_en,
	input  wire logic sw_force_level,
	input  wire logic internal_reset_req,
	input  wire logic park_done,
	output var  logic park_req_q,
	output var  logic controller_reset_q,
	output var  logic power_good_ok_q,
	output var  logic external_reset_pin_n_q
);
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic pos_s;
	logic pg_s;

	psrc_sync u_sync_pos (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (power_on_sense),
		.level_q  (pos_s)
	);

	psrc_sync u_sync_pg (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (power_good_in),
		.level_q  (pg_s)
	);

	// ---------------------------------------------------------------
	// power-good qualification and controller sequencing
	// ---------------------------------------------------------------
	psrc_state_t      state_q;
	psrc_state_t      state_d;
	logic [CNT_W-1:0] pg_cnt_q;
	logic [CNT_W-1:0] pg_cnt_d;
	logic             park_req_d;
	logic             ctrl_rst_d;
	logic             pg_ok_d;
	logic             pg_event;

	// low pulses shorter than the window are glitches and never reach park
	always_comb begin
		state_d    = state_q;
		pg_cnt_d   = pg_cnt_q;
		park_req_d = 1'b0;
		ctrl_rst_d = 1'b1;
		pg_ok_d    = 1'b0;
		pg_event   = 1'b0;
		case (state_q)
			PSRC_RUN: begin
				ctrl_rst_d = 1'b0;
				pg_ok_d    = 1'b1;
				if (pg_s) begin
					pg_cnt_d = '0;
				end else if (pg_cnt_q >= CNT_W'(PG_LOW_CYC - 1)) begin
					state_d    = PSRC_PARK;
					park_req_d = 1'b1;
					ctrl_rst_d = 1'b0;
					pg_ok_d    = 1'b0;
					pg_event   = 1'b1;
					pg_cnt_d   = '0;
				end else begin
					pg_cnt_d = pg_cnt_q + CNT_W'(1);
				end
			end
			PSRC_PARK: begin
				// park first, reset after; controller still alive here
				ctrl_rst_d = 1'b0;
				park_req_d = 1'b1;
				if (park_done) begin
					state_d    = PSRC_HOLD;
					park_req_d = 1'b0;
					ctrl_rst_d = 1'b1;
				end
			end
			PSRC_HOLD: begin
				pg_cnt_d = '0;
				if (pg_s) begin
					state_d = PSRC_QUAL;
				end
			end
			PSRC_QUAL: begin
				if (!pg_s) begin
					state_d  = PSRC_HOLD;
					pg_cnt_d = '0;
				end else if (pg_cnt_q >= CNT_W'(PG_HIGH_CYC - 1)) begin
					state_d    = PSRC_RUN;
					ctrl_rst_d = 1'b0;
					pg_ok_d    = 1'b1;
					pg_cnt_d   = '0;
				end else begin
					pg_cnt_d = pg_cnt_q + CNT_W'(1);
				end
			end
			default: begin
				state_d  = PSRC_HOLD;
				pg_cnt_d = '0;
			end
		endcase
	end

	// controller starts in reset and must see power-good qualified
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q            <= PSRC_HOLD;
			pg_cnt_q           <= '0;
			park_req_q         <= 1'b0;
			controller_reset_q <= 1'b1;
			power_good_ok_q    <= 1'b0;
		end else begin
			state_q            <= state_d;
			pg_cnt_q           <= pg_cnt_d;
			park_req_q         <= park_req_d;
			controller_reset_q <= ctrl_rst_d;
			power_good_ok_q    <= pg_ok_d;
		end
	end

	// ---------------------------------------------------------------
	// external reset output
	// ---------------------------------------------------------------
	logic             hold_q;
	logic             hold_d;
	logic             dly_act_q;
	logic             dly_act_d;
	logic [CNT_W-1:0] dly_cnt_q;
	logic [CNT_W-1:0] dly_cnt_d;
	logic [CNT_W-1:0] str_cnt_q;
	logic [CNT_W-1:0] str_cnt_d;
	logic             ext_d;
	logic             assert_now;

	// auto reset: held on power-on sense low or on delayed-event expiry,
	// released by software only; the stretch counter gates any release
	always_comb begin
		hold_d     = hold_q;
		dly_act_d  = dly_act_q;
		dly_cnt_d  = dly_cnt_q;
		str_cnt_d  = str_cnt_q;
		assert_now = 1'b0;
		// delayed assertion after power-good loss or internal reset
		if (pg_event || internal_reset_req) begin
			dly_act_d = 1'b1;
			dly_cnt_d = '0;
		end else if (dly_act_q) begin
			if (dly_cnt_q >= CNT_W'(EXT_DELAY_CYC - 1)) begin
				dly_act_d  = 1'b0;
				assert_now = 1'b1;
			end else begin
				dly_cnt_d = dly_cnt_q + CNT_W'(1);
			end
		end
		if (!pos_s) begin
			hold_d     = 1'b1;
			assert_now = 1'b1;
		end else if (assert_now) begin
			hold_d = 1'b1;
		end else if (sw_release && str_cnt_q == '0) begin
			hold_d = 1'b0;
		end
		// restart the stretch on every assertion, count down otherwise
		if (assert_now || (hold_d && !hold_q)) begin
			str_cnt_d = CNT_W'(STRETCH_CYCLES - 1);
		end else if (str_cnt_q != '0) begin
			str_cnt_d = str_cnt_q - CNT_W'(1);
		end
		// software force overrides the automatic sequencing
		if (sw_force_en) begin
			ext_d = sw_force_level;
		end else begin
			ext_d = !hold_d;
		end
	end

	// reset holds the part in external reset until software releases it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hold_q                 <= 1'b1;
			dly_act_q              <= 1'b0;
			dly_cnt_q              <= '0;
			str_cnt_q              <= CNT_W'(STRETCH_CYCLES - 1);
			external_reset_pin_n_q <= 1'b0;
		end else begin
			hold_q                 <= hold_d;
			dly_act_q              <= dly_act_d;
			dly_cnt_q              <= dly_cnt_d;
			str_cnt_q              <= str_cnt_d;
			external_reset_pin_n_q <= ext_d;
		end
	end
endmodule
`default_nettype wire

// *** verification/psrc_monitor.sv ***
// port checker for the power sense reset control block
`timescale 1ns/100ps
`default_nettype none
module psrc_monitor
	import psrc_pkg::*;
#(
	parameter int STRETCH_CYCLES = STRETCH_CYC
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic power_on_sense,
	input  wire logic power_good_in,
	input  wire logic sw_release,
	input  wire logic sw_force_en,
	input  wire logic sw_force_level,
	input  wire logic internal_reset_req,
	input  wire logic park_done,
	input  wire logic park_req_q,
	input  wire logic controller_reset_q,
	input  wire logic power_good_ok_q,
	input  wire logic external_reset_pin_n_q
);
	localparam int DLY_LO = EXT_DELAY_CYC - 5;
	localparam int DLY_HI = EXT_DELAY_CYC + 8;
	int lo_q;
	int pgl_q;
	int pgh_q;
	// ------------------------------------------------------------
	// run lengths; raw pins, so they bound the synced view
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		lo_q  <= external_reset_pin_n_q ? 0 : lo_q + 1;
		pgl_q <= power_good_in ? 0 : pgl_q + 1;
		pgh_q <= power_good_in ? pgh_q + 1 : 0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_auto_rise;
		$rose(external_reset_pin_n_q) && !$past(sw_force_en);
	endsequence
	chk_sense_low: assert property (
		(!power_on_sense && !sw_force_en)[*6] |-> !external_reset_pin_n_q)
		else $error("pin high with sense low");
	chk_sw_release: assert property (
		s_auto_rise |-> $past(sw_release)) else $error("release unasked");
	chk_int_delay: assert property (
		internal_reset_req && !sw_force_en |->
		##[DLY_LO:DLY_HI] !external_reset_pin_n_q) else $error("no drop");
	chk_stretch_min: assert property (
		s_auto_rise |-> lo_q >= STRETCH_CYCLES) else $error("short low");
	chk_force_drive: assert property (
		(sw_force_en && $stable(sw_force_level))[*3] |->
		external_reset_pin_n_q == sw_force_level) else $error("force lost");
	chk_park_filter: assert property (
		$rose(park_req_q) |-> pgl_q >= PG_LOW_CYC) else $error("glitch park");
	chk_park_reset: assert property (
		park_req_q && park_done |=> controller_reset_q) else $error("no rst");
	// raw pin leads the synced view by four flops, so allow that lag
	chk_hold_low: assert property (
		controller_reset_q && pgl_q >= 4 |=> controller_reset_q)
		else $error("left reset");
	chk_ok_qual: assert property (
		$rose(power_good_ok_q) |-> pgh_q >= PG_HIGH_CYC)
		else $error("early good");
	chk_pg_qual: assert property (
		$fell(controller_reset_q) |-> pgh_q >= PG_HIGH_CYC)
		else $error("early run");
endmodule
bind psrc_top psrc_monitor #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_mon (
	.core_clk(core_clk), .reset(reset), .power_on_sense(power_on_sense),
	.power_good_in(power_good_in), .sw_release(sw_release),
	.sw_force_en(sw_force_en), .sw_force_level(sw_force_level),
	.internal_reset_req(internal_reset_req), .park_done(park_done),
	.park_req_q(park_req_q), .controller_reset_q(controller_reset_q),
	.power_good_ok_q(power_good_ok_q),
	.external_reset_pin_n_q(external_reset_pin_n_q));
`default_nettype wire

// *** verification/psrc_supply_model.sv ***
// voltage monitor and supply model driving the two sense pins
`timescale 1ns/100ps
`default_nettype none
module psrc_supply_model (
	input  wire logic core_clk,
	input  wire logic drop,
	input  wire logic glitch,
	output wire logic power_on_sense,
	output wire logic power_good_in
);
	int cnt_q = 0;
	// power-good leads sense going down and trails it coming up
	always @(posedge core_clk) begin
		if (drop) begin
			cnt_q <= (cnt_q < 20) ? cnt_q + 1 : 20;
		end else begin
			cnt_q <= (cnt_q > 0) ? cnt_q - 1 : 0;
		end
	end
	assign power_on_sense = cnt_q < 20;
	assign power_good_in  = !drop && !glitch && cnt_q == 0;
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the power sense reset control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import psrc_pkg::*;
	localparam int SC = 50;
	logic core_clk = 1'b0, reset = 1'b1, drop = 1'b0, glitch = 1'b0;
	logic sw_release = 1'b0, sw_force_en = 1'b0, sw_force_level = 1'b0;
	logic internal_reset_req = 1'b0, park_done = 1'b0;
	wire logic power_on_sense, power_good_in;
	logic park_req_q, controller_reset_q, power_good_ok_q, pin_n;
	int n_mismatch = 0, compares = 0, seed = 25;
	always #5 core_clk = ~core_clk;
	// mirror side answers the park request one cycle later
	always @(posedge core_clk) park_done <= #1 park_req_q;
	psrc_supply_model i_sup (.core_clk(core_clk), .drop(drop), .glitch(glitch),
		.power_on_sense(power_on_sense), .power_good_in(power_good_in));
	psrc_top #(.STRETCH_CYCLES(SC)) i_dut (.core_clk(core_clk), .reset(reset),
		.power_on_sense(power_on_sense), .power_good_in(power_good_in),
		.sw_release(sw_release), .sw_force_en(sw_force_en),
		.sw_force_level(sw_force_level), .park_done(park_done),
		.internal_reset_req(internal_reset_req), .park_req_q(park_req_q),
		.controller_reset_q(controller_reset_q),
		.power_good_ok_q(power_good_ok_q), .external_reset_pin_n_q(pin_n));
	task automatic chk(input string nm, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %b got %b", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		cyc(5);
		reset = 1'b0;
		cyc(PG_HIGH_CYC + 100);
		chk("ok", power_good_ok_q, 1'b1);
		chk("pin", pin_n, 1'b0);
		sw_release = 1'b1;
		cyc(3);
		chk("pin", pin_n, 1'b1);
		glitch = 1'b1;
		cyc(10 + {$random(seed)} % 80);
		glitch = 1'b0;
		cyc(200);
		chk("park", park_req_q, 1'b0);
		chk("ctl", controller_reset_q, 1'b0);
		internal_reset_req = 1'b1;
		cyc(1);
		internal_reset_req = 1'b0;
		cyc(EXT_DELAY_CYC - 10);
		chk("pin", pin_n, 1'b1);
		cyc(20);
		chk("pin", pin_n, 1'b0);
		cyc(SC - 20);
		chk("pin", pin_n, 1'b0);
		cyc(100);
		chk("pin", pin_n, 1'b1);
		drop = 1'b1;
		cyc(26);
		chk("pin", pin_n, 1'b0);
		cyc(PG_LOW_CYC - 21);
		chk("park", park_req_q, 1'b1);
		chk("ctl", controller_reset_q, 1'b0);
		chk("ok", power_good_ok_q, 1'b0);
		cyc(51);
		chk("ctl", controller_reset_q, 1'b1);
		sw_force_en = 1'b1;
		sw_force_level = 1'b1;
		cyc(3);
		chk("pin", pin_n, 1'b1);
		sw_force_level = 1'b0;
		cyc(3);
		chk("pin", pin_n, 1'b0);
		sw_force_en = 1'b0;
		drop = 1'b0;
		cyc(PG_HIGH_CYC / 2);
		chk("ctl", controller_reset_q, 1'b1);
		cyc(PG_HIGH_CYC);
		chk("ctl", controller_reset_q, 1'b0);
		chk("ok", power_good_ok_q, 1'b1);
		tally_and_finish();
	end
	// watchdog well past the expected run length
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
